// file: verilog/hdlrx_pkg.sv
// Package of constants shared by both ends of the link receiver
package hdlrx_pkg;
	// =========================================
	// Link receiver register map
	localparam logic [1:0] REG_CONFIG   = 2'h0;
	localparam logic [1:0] REG_IRQ_CTRL = 2'h1;
	localparam logic [1:0] REG_STATUS   = 2'h2;
	localparam logic [1:0] REG_DATA     = 2'h3;
	// Configuration fields
	localparam int CFG_EN       = 0;
	localparam int CFG_ADDR_EN  = 1;
	localparam int CFG_PRIM_LSB = 8;
	localparam int CFG_SEC_LSB  = 16;
	localparam logic [7:0] UNIVERSAL_ADDR = 8'hFF;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	// Interrupt control fields
	localparam int IRQ_EN_BIT   = 7;
	localparam logic [7:0] IRQ_CTRL_RESET = 8'h08;
	// Status fields
	localparam int ST_IRQ_PENDING = 0;
	localparam int ST_LINK_CHG    = 1;
	localparam int ST_PKT_END     = 2;
	localparam int ST_OVERRUN     = 3;
	localparam int ST_EMPTY       = 4;
	localparam int ST_CODE_LSB    = 5;
	// Byte status codes
	localparam logic [2:0] CODE_DATA      = 3'h0;
	localparam logic [2:0] CODE_LINK_UP   = 3'h1;
	localparam logic [2:0] CODE_LINK_DOWN = 3'h2;
	localparam logic [2:0] CODE_END       = 3'h4;
	localparam int CODE_CRC_BIT = 1;
	localparam int CODE_NIB_BIT = 0;
	// Serial patterns and CRC
	localparam logic [7:0] FLAG_PATTERN  = 8'h7E;
	localparam logic [7:0] ABORT_PATTERN = 8'h7F;
	localparam logic [15:0] CRC_INIT     = 16'hFFFF;
	localparam logic [15:0] CRC_GOOD     = 16'hF0B8;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	// FIFO and timing
	localparam int FIFO_DEPTH  = 128;
	localparam int FIFO_AW     = 7;
	localparam int ACCESS_DIV  = 10;
	localparam int BIT_DIV     = 16;
endpackage

// file: verilog/hdlrx_if.sv
// Interface joining the link receiver and its host
`timescale 1ns/1ps
interface hdlrx_if;
	logic [1:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        irq;
	modport dev
	(
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata,
		output irq
	);
	modport host
	(
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata,
		input  irq
	);
endinterface

// file: verilog/hdlrx_receiver.sv
// Link receiver: serial deframer, byte FIFO and register slave
`timescale 1ns/1ps
module hdlrx_receiver
(
	input  wire logic CORE_CLK,
	input  wire logic ARST_N,
	input  wire logic RX_DATA,
	input  wire logic RX_BIT_EN,
	hdlrx_if.dev      BUS
);
	// =========================================
	// Input synchronisers
	logic [1:0] d_sync;
	logic [1:0] e_sync;
	logic       e_prev;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			d_sync <= 2'h3;
			e_sync <= 2'h0;
			e_prev <= 1'b0;
		end
		else
		begin
			d_sync <= {d_sync[0], RX_DATA};
			e_sync <= {e_sync[0], RX_BIT_EN};
			e_prev <= e_sync[1];
		end
	end
	logic bit_tick;
	assign bit_tick = e_sync[1] & ~e_prev;

	// =========================================
	// Registers
	logic [31:0] cfg;
	logic [7:0]  irq_ctrl;
	logic        link_state_changed;
	logic        packet_end_seen;
	logic        fifo_overrun_flag;
	logic        enabled;
	assign enabled = cfg[hdlrx_pkg::CFG_EN];

	// =========================================
	// Deframer
	typedef enum logic [1:0] {HDLRX_IDLE, HDLRX_SYNC, HDLRX_FRAME} hdlrx_state_e;
	hdlrx_state_e state;
	logic [7:0]  shreg;
	logic [2:0]  ones;
	logic [7:0]  acc;
	logic [3:0]  nbits;
	logic [15:0] crc;
	logic [7:0]  hold;
	logic        hold_ok;
	logic        addr_chk;
	logic        frame_drop;
	logic [7:0]  win;
	logic        is_flag;
	logic        is_abort;
	logic        stuffed;
	logic [15:0] next_crc;
	assign win      = {d_sync[1], shreg[7:1]};
	assign is_flag  = win == hdlrx_pkg::FLAG_PATTERN;
	assign is_abort = win == hdlrx_pkg::ABORT_PATTERN;
	assign stuffed  = (ones == 3'h5) && !d_sync[1];
	always_comb
	begin
		next_crc = crc;
		for (int i = 0; i < 8; i++)
		begin
			if (next_crc[0] ^ hold[i])
				next_crc = (next_crc >> 1) ^ hdlrx_pkg::CRC_POLY_REV;
			else
				next_crc = next_crc >> 1;
		end
	end

	logic       push;
	logic [7:0] push_byte;
	logic [2:0] push_code;
	logic       addr_match;
	// Compared with the byte completing on this bit
	assign addr_match = !cfg[hdlrx_pkg::CFG_ADDR_EN]
		|| {d_sync[1], acc[7:1]} == cfg[hdlrx_pkg::CFG_PRIM_LSB +: 8]
		|| {d_sync[1], acc[7:1]} == cfg[hdlrx_pkg::CFG_SEC_LSB +: 8]
		|| {d_sync[1], acc[7:1]} == hdlrx_pkg::UNIVERSAL_ADDR;

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state      <= HDLRX_IDLE;
			shreg      <= 8'hFF;
			ones       <= 3'h0;
			acc        <= 8'h00;
			nbits      <= 4'h0;
			crc        <= hdlrx_pkg::CRC_INIT;
			hold       <= 8'h00;
			hold_ok    <= 1'b0;
			addr_chk   <= 1'b0;
			frame_drop <= 1'b0;
			push       <= 1'b0;
			push_byte  <= 8'h00;
			push_code  <= 3'h0;
		end
		else
		begin
			push <= 1'b0;
			if (!enabled)
			begin
				state <= HDLRX_IDLE;
				shreg <= 8'hFF;
				ones  <= 3'h0;
			end
			else if (bit_tick)
			begin
				shreg <= win;
				ones  <= d_sync[1] ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
				if (is_abort)
				begin
					if (state != HDLRX_IDLE)
					begin
						push      <= 1'b1;
						push_byte <= 8'h00;
						push_code <= hdlrx_pkg::CODE_LINK_DOWN;
					end
					state <= HDLRX_IDLE;
				end
				else if (is_flag)
				begin
					if (state == HDLRX_IDLE)
					begin
						push      <= 1'b1;
						push_byte <= 8'h00;
						push_code <= hdlrx_pkg::CODE_LINK_UP;
					end
					else if (state == HDLRX_FRAME && hold_ok && !frame_drop)
					begin
						push      <= 1'b1;
						push_byte <= hold;
						push_code <= hdlrx_pkg::CODE_END
							| {1'b0, next_crc != hdlrx_pkg::CRC_GOOD, nbits != 4'h7};
					end
					state    <= HDLRX_SYNC;
					nbits    <= 4'h0;
					hold_ok  <= 1'b0;
					addr_chk <= 1'b1;
					frame_drop <= 1'b0;
					crc      <= hdlrx_pkg::CRC_INIT;
				end
				else if (state != HDLRX_IDLE && !stuffed)
				begin
					acc   <= {d_sync[1], acc[7:1]};
					nbits <= (nbits == 4'h7) ? 4'h0 : nbits + 4'h1;
					if (nbits == 4'h7)
					begin
						state <= HDLRX_FRAME;
						if (addr_chk && !addr_match)
							frame_drop <= 1'b1;
						addr_chk <= 1'b0;
						if (hold_ok && !frame_drop)
						begin
							push      <= 1'b1;
							push_byte <= hold;
							push_code <= hdlrx_pkg::CODE_DATA;
						end
						if (hold_ok)
							crc <= next_crc;
						hold    <= {d_sync[1], acc[7:1]};
						hold_ok <= 1'b1;
					end
				end
			end
		end
	end

	// =========================================
	// FIFO
	logic [7:0] fifo_byte [hdlrx_pkg::FIFO_DEPTH];
	logic [2:0] fifo_code [hdlrx_pkg::FIFO_DEPTH];
	logic [hdlrx_pkg::FIFO_AW-1:0] wptr;
	logic [hdlrx_pkg::FIFO_AW-1:0] rptr;
	logic [hdlrx_pkg::FIFO_AW:0]   count;
	logic data_rd;
	logic stat_rd;
	logic pop;
	logic full;
	logic overrun;
	assign data_rd = BUS.rd && BUS.addr == hdlrx_pkg::REG_DATA;
	assign stat_rd = BUS.rd && BUS.addr == hdlrx_pkg::REG_STATUS;
	assign pop     = data_rd && count != '0;
	assign full    = count == (hdlrx_pkg::FIFO_AW+1)'(hdlrx_pkg::FIFO_DEPTH);
	assign overrun = push && full && !pop;
	always_ff @(posedge CORE_CLK)
	begin
		if (push && (!full || pop))
		begin
			fifo_byte[wptr] <= push_byte;
			fifo_code[wptr] <= push_code;
		end
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end
		else if (overrun || !enabled)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end
		else
		begin
			wptr  <= (push && (!full || pop)) ? wptr + 1'b1 : wptr;
			rptr  <= pop ? rptr + 1'b1 : rptr;
			count <= count + (hdlrx_pkg::FIFO_AW+1)'(push && (!full || pop)) - (hdlrx_pkg::FIFO_AW+1)'(pop);
		end
	end

	// =========================================
	// Status flags, set wins over clear by status read; fill_hit clears only when the FIFO is empty
	logic [2:0] last_code;
	logic       fill_hit;
	logic       irq_pending;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			link_state_changed <= 1'b0;
			packet_end_seen    <= 1'b0;
			fifo_overrun_flag  <= 1'b0;
			fill_hit           <= 1'b0;
			last_code          <= 3'h0;
		end
		else
		begin
			if (push && push_code[2:1] == 2'h0 && push_code[0] || push && push_code == hdlrx_pkg::CODE_LINK_DOWN)
				link_state_changed <= 1'b1;
			else if (stat_rd)
				link_state_changed <= 1'b0;
			if (push && push_code[2])
				packet_end_seen <= 1'b1;
			else if (stat_rd)
				packet_end_seen <= 1'b0;
			if (overrun)
				fifo_overrun_flag <= 1'b1;
			else if (stat_rd)
				fifo_overrun_flag <= 1'b0;
			if (count > {1'b0, irq_ctrl[hdlrx_pkg::FIFO_AW-1:0]})
				fill_hit <= 1'b1;
			else if (count == '0)
				fill_hit <= 1'b0;
			if (pop)
				last_code <= fifo_code[rptr];
		end
	end
	assign irq_pending = link_state_changed | packet_end_seen | fifo_overrun_flag | fill_hit;

	// =========================================
	// Register writes and read data
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cfg      <= hdlrx_pkg::CFG_RESET;
			irq_ctrl <= hdlrx_pkg::IRQ_CTRL_RESET;
		end
		else if (BUS.wr)
		begin
			if (BUS.addr == hdlrx_pkg::REG_CONFIG)
				cfg <= BUS.wdata;
			if (BUS.addr == hdlrx_pkg::REG_IRQ_CTRL)
				irq_ctrl <= BUS.wdata[7:0];
		end
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			BUS.rdata <= 32'h0000_0000;
		else if (BUS.rd)
		begin
			unique case (BUS.addr)
				hdlrx_pkg::REG_CONFIG:   BUS.rdata <= cfg;
				hdlrx_pkg::REG_IRQ_CTRL: BUS.rdata <= {24'h0, irq_ctrl};
				hdlrx_pkg::REG_STATUS:   BUS.rdata <= {24'h0, last_code, count == '0,
					fifo_overrun_flag, packet_end_seen, link_state_changed, irq_pending};
				hdlrx_pkg::REG_DATA:     BUS.rdata <= {24'h0, (count != '0) ? fifo_byte[rptr] : 8'h00};
			endcase
		end
	end
	assign BUS.irq = irq_pending & irq_ctrl[hdlrx_pkg::IRQ_EN_BIT];
endmodule

// file: verilog/hdlrx_host.sv
// Host end: drains the link receiver by alternating data and status reads
`timescale 1ns/1ps
module hdlrx_host
(
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic [7:0]  IRQ_CTRL,
	input  wire logic [31:0] CFG,
	input  wire logic        START,
	input  wire logic        POLL,
	output logic             BYTE_VALID,
	output logic [7:0]       BYTE_DATA,
	output logic [2:0]       BYTE_CODE,
	output logic             LINK_ACTIVE_SW,
	output logic [15:0]      PACKET_COUNT,
	output logic             BUSY,
	hdlrx_if.host            BUS
);
	typedef enum logic [2:0] {HDLRX_H_RESET, HDLRX_H_CFG, HDLRX_H_WAIT, HDLRX_H_STAT,
		HDLRX_H_STAT_RD, HDLRX_H_DATA, HDLRX_H_DATA_RD} hdlrx_hstate_e;
	hdlrx_hstate_e state;
	logic [3:0] gap;
	logic       drain;
	logic [7:0] data_byte;
	logic       irq_mode;
	logic       data_pend;
	assign irq_mode = IRQ_CTRL[hdlrx_pkg::IRQ_EN_BIT];
	assign BUSY = state != HDLRX_H_WAIT;

	// =========================================
	// Access spacing and service loop
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state          <= HDLRX_H_RESET;
			gap            <= 4'h0;
			drain          <= 1'b0;
			data_byte      <= 8'h00;
			BUS.addr       <= 2'h0;
			BUS.wdata      <= 32'h0;
			BUS.wr         <= 1'b0;
			BUS.rd         <= 1'b0;
			BYTE_VALID     <= 1'b0;
			BYTE_DATA      <= 8'h00;
			BYTE_CODE      <= 3'h0;
			LINK_ACTIVE_SW <= 1'b0;
			PACKET_COUNT   <= 16'h0;
		end
		else
		begin
			BUS.wr     <= 1'b0;
			BUS.rd     <= 1'b0;
			BYTE_VALID <= 1'b0;
			if (gap != 4'h0)
				gap <= gap - 4'h1;
			else
			begin
				unique case (state)
					HDLRX_H_RESET:
					begin
						BUS.wr    <= 1'b1;
						BUS.addr  <= hdlrx_pkg::REG_IRQ_CTRL;
						BUS.wdata <= {24'h0, IRQ_CTRL};
						gap       <= 4'(hdlrx_pkg::ACCESS_DIV - 1);
						state     <= HDLRX_H_CFG;
					end
					HDLRX_H_CFG:
						if (START)
						begin
							BUS.wr    <= 1'b1;
							BUS.addr  <= hdlrx_pkg::REG_CONFIG;
							BUS.wdata <= CFG;
							gap       <= 4'(hdlrx_pkg::ACCESS_DIV - 1);
							state     <= HDLRX_H_WAIT;
						end
					HDLRX_H_WAIT:
						if ((irq_mode && BUS.irq) || POLL)
						begin
							drain    <= 1'b0;
							BUS.rd   <= 1'b1;
							BUS.addr <= hdlrx_pkg::REG_STATUS;
							gap      <= 4'h1;
							state    <= HDLRX_H_STAT_RD;
						end
					HDLRX_H_STAT:
					begin
						BUS.rd   <= 1'b1;
						BUS.addr <= hdlrx_pkg::REG_STATUS;
						gap      <= 4'h1;
						state    <= HDLRX_H_STAT_RD;
					end
					// Read data stand from the cycle after the strobe until the next read
					HDLRX_H_STAT_RD:
					begin
						gap <= 4'(hdlrx_pkg::ACCESS_DIV - 3);
						if (BUS.rdata[hdlrx_pkg::ST_OVERRUN])
							state <= HDLRX_H_WAIT;
						else
						begin
							if (BUS.rdata[hdlrx_pkg::ST_PKT_END])
								PACKET_COUNT <= PACKET_COUNT + 16'h1;
							if (BUS.rdata[hdlrx_pkg::ST_LINK_CHG] || BUS.rdata[hdlrx_pkg::ST_PKT_END])
								drain <= 1'b1;
							if (!BUS.rdata[hdlrx_pkg::ST_EMPTY] && (BUS.rdata[hdlrx_pkg::ST_IRQ_PENDING]
								|| drain || BUS.rdata[hdlrx_pkg::ST_LINK_CHG] || BUS.rdata[hdlrx_pkg::ST_PKT_END]))
								state <= HDLRX_H_DATA;
							else
								state <= HDLRX_H_WAIT;
						end
					end
					HDLRX_H_DATA:
					begin
						BUS.rd   <= 1'b1;
						BUS.addr <= hdlrx_pkg::REG_DATA;
						gap      <= 4'h1;
						state    <= HDLRX_H_DATA_RD;
					end
					HDLRX_H_DATA_RD:
					begin
						data_byte <= BUS.rdata[7:0];
						gap       <= 4'(hdlrx_pkg::ACCESS_DIV - 3);
						state     <= HDLRX_H_STAT;
					end
				endcase
			end
			if (state == HDLRX_H_STAT_RD && gap == 4'h0 && BUS.addr == hdlrx_pkg::REG_STATUS && data_pend)
			begin
				BYTE_VALID <= 1'b1;
				BYTE_DATA  <= data_byte;
				BYTE_CODE  <= BUS.rdata[hdlrx_pkg::ST_CODE_LSB +: 3];
				if (BUS.rdata[hdlrx_pkg::ST_CODE_LSB +: 3] == hdlrx_pkg::CODE_LINK_UP)
					LINK_ACTIVE_SW <= 1'b1;
				else if (BUS.rdata[hdlrx_pkg::ST_CODE_LSB +: 3] == hdlrx_pkg::CODE_LINK_DOWN)
					LINK_ACTIVE_SW <= 1'b0;
			end
		end
	end

	// =========================================
	// Marks a status read that follows a data read
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			data_pend <= 1'b0;
		else if (state == HDLRX_H_DATA_RD && gap == 4'h0)
			data_pend <= 1'b1;
		else if (state == HDLRX_H_STAT_RD && gap == 4'h0)
			data_pend <= 1'b0;
	end
endmodule

// file: dv/hdlrx_props.sv
// Checker of the register traffic between host and receiver
`timescale 1ns/1ps
module hdlrx_props
(
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	input wire logic [1:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        irq
);
	// ====
	// Interrupt enable and set-up order seen on the bus
	logic irq_en;
	logic ictrl_done;
	always_ff @(posedge CORE_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			irq_en     <= hdlrx_pkg::IRQ_CTRL_RESET[hdlrx_pkg::IRQ_EN_BIT];
			ictrl_done <= 1'b0;
		end
		else if (wr && addr == hdlrx_pkg::REG_IRQ_CTRL)
		begin
			irq_en     <= wdata[hdlrx_pkg::IRQ_EN_BIT];
			ictrl_done <= 1'b1;
		end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// ====
	// Properties
	property p_spacing;
		(rd || wr) |=> !(rd || wr) [*8] ##1 !(rd || wr);
	endproperty
	a_spacing: assert property (p_spacing) else $error("accesses too close");
	property p_quiet;
		$rose(ARST_N) |-> !irq && rdata == 32'h0000_0000;
	endproperty
	a_quiet: assert property (p_quiet) else $error("not quiet after reset");
	property p_order;
		wr && addr == hdlrx_pkg::REG_CONFIG && wdata[hdlrx_pkg::CFG_EN] |-> ictrl_done;
	endproperty
	a_order: assert property (p_order) else $error("enabled before irq set-up");
	property p_gate;
		!irq_en |-> !irq;
	endproperty
	a_gate: assert property (p_gate) else $error("irq while disabled");
	property p_alt;
		rd && addr == hdlrx_pkg::REG_DATA |-> ##[10:60] rd && addr == hdlrx_pkg::REG_STATUS;
	endproperty
	a_alt: assert property (p_alt) else $error("data read not followed by status");
	property p_code;
		rd && addr == hdlrx_pkg::REG_STATUS |=> rdata[hdlrx_pkg::ST_CODE_LSB +: 3] != 3'h3;
	endproperty
	a_code: assert property (p_code) else $error("illegal byte code");
	property p_level;
		rd && addr == hdlrx_pkg::REG_STATUS && irq |=> rdata[hdlrx_pkg::ST_IRQ_PENDING];
	endproperty
	a_level: assert property (p_level) else $error("irq without pending bit");
	property p_wregs;
		wr |-> addr == hdlrx_pkg::REG_CONFIG || addr == hdlrx_pkg::REG_IRQ_CTRL;
	endproperty
	a_wregs: assert property (p_wregs) else $error("write to read-only place");
endmodule

// file: dv/hdlc_data_link_receiver_tb.sv
// Testbench joining both ends of the link receiver
`timescale 1ns/1ps
module hdlc_data_link_receiver_tb;
	typedef struct { int n; logic [7:0] b0; logic bad; logic [2:0] code; } hdlrx_row_s;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        rx_data = 1'b1;
	logic        rx_bit_en = 1'b0;
	logic [7:0]  irq_ctrl = 8'h88;
	logic        start = 1'b0;
	logic        poll = 1'b0;
	logic [31:0] cfg_word = 32'h0000_0001;
	logic        busy;
	logic        byte_valid;
	logic [7:0]  byte_data;
	logic [2:0]  byte_code;
	logic        link_active;
	logic [15:0] pkt_cnt;
	logic [15:0] crc;
	logic [2:0]  exp_c[$];
	logic [2:0]  got_c[$];
	logic [8:0]  exp_d[$];
	logic [7:0]  got_d[$];
	int          err_total = 0;
	int          tests_run = 0;
	int          ones = 0;
	hdlrx_row_s  rows[4] = '{'{1, 8'h7E, 1'b0, 3'h4}, '{3, 8'hFE, 1'b0, 3'h4},
		'{9, 8'h10, 1'b0, 3'h4}, '{2, 8'hF0, 1'b1, 3'h6}};
	hdlrx_if i_hdlrx_if ();
	hdlrx_receiver i_hdlrx_receiver (.CORE_CLK(core_clk), .ARST_N(arst_n), .RX_DATA(rx_data),
		.RX_BIT_EN(rx_bit_en), .BUS(i_hdlrx_if));
	hdlrx_host i_hdlrx_host (.CORE_CLK(core_clk), .ARST_N(arst_n), .IRQ_CTRL(irq_ctrl),
		.CFG(cfg_word), .START(start), .POLL(poll), .BYTE_VALID(byte_valid),
		.BYTE_DATA(byte_data), .BYTE_CODE(byte_code), .LINK_ACTIVE_SW(link_active),
		.PACKET_COUNT(pkt_cnt), .BUSY(busy), .BUS(i_hdlrx_if));
	hdlrx_props i_hdlrx_props (.CORE_CLK(core_clk), .ARST_N(arst_n), .addr(i_hdlrx_if.addr),
		.wdata(i_hdlrx_if.wdata), .wr(i_hdlrx_if.wr), .rd(i_hdlrx_if.rd),
		.rdata(i_hdlrx_if.rdata), .irq(i_hdlrx_if.irq));
	initial
		forever #4 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (byte_valid === 1'b1)
		begin
			got_c.push_back(byte_code);
			got_d.push_back(byte_data);
		end
	// ====
	// Tasks
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bit_out(input logic b);
		rx_data   <= b;
		rx_bit_en <= 1'b0;
		repeat (8) @(posedge core_clk);
		rx_bit_en <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask
	// Least significant bit first, zero after five ones unless raw
	task automatic byte_out(input logic [7:0] v, input logic raw);
		for (int i = 0; i < 8; i++)
		begin
			crc = (crc >> 1) ^ ((crc[0] ^ v[i]) ? hdlrx_pkg::CRC_POLY_REV : 16'h0000);
			bit_out(v[i]);
			ones = v[i] ? ones + 1 : 0;
			if (!raw && ones == 5)
			begin
				bit_out(1'b0);
				ones = 0;
			end
		end
		if (raw)
			ones = 0;
	endtask
	task automatic want(input logic [2:0] c, input logic [8:0] d);
		exp_c.push_back(c);
		exp_d.push_back(d);
	endtask
	task automatic packet(input hdlrx_row_s r);
		logic [15:0] fcs;
		crc = hdlrx_pkg::CRC_INIT;
		for (int i = 0; i < r.n; i++)
		begin
			byte_out(r.b0 + 8'(i), 1'b0);
			want(hdlrx_pkg::CODE_DATA, {1'b0, r.b0 + 8'(i)});
		end
		fcs = ~crc ^ {15'h0000, r.bad};
		byte_out(fcs[7:0], 1'b0);
		byte_out(fcs[15:8], 1'b0);
		byte_out(hdlrx_pkg::FLAG_PATTERN, 1'b1);
		want(hdlrx_pkg::CODE_DATA, {1'b0, fcs[7:0]});
		want(r.code, {1'b0, fcs[15:8]});
	endtask
	task automatic drain(input string name);
		int k;
		k = 0;
		while (got_c.size() < exp_c.size() && k < 20000)
		begin
			@(posedge core_clk);
			k++;
		end
		if (k == 20000)
		begin
			err_total++;
			end_of_test();
		end
		chk("byte count", 16'(exp_c.size()), 16'(got_c.size()));
		foreach (exp_c[i])
		begin
			chk("byte code", 16'(exp_c[i]), 16'(got_c[i]));
			if (!exp_d[i][8])
				chk("byte data", 16'(exp_d[i][7:0]), 16'(got_d[i]));
		end
		exp_c.delete();
		exp_d.delete();
		got_c.delete();
		got_d.delete();
		$display("test %s done", name);
	endtask
	task automatic link_up();
		repeat (8) bit_out(1'b1);
		byte_out(hdlrx_pkg::FLAG_PATTERN, 1'b1);
		want(hdlrx_pkg::CODE_LINK_UP, 9'h100);
	endtask
	// ====
	// Main sequence
	initial
	begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("link active", 16'h0000, {15'h0000, link_active});
		chk("packet count", 16'h0000, pkt_cnt);
		byte_out(hdlrx_pkg::FLAG_PATTERN, 1'b1);
		start <= 1'b1;
		link_up();
		drain("link up");
		chk("link active", 16'h0001, {15'h0000, link_active});
		chk("busy", 16'h0000, {15'h0000, busy});
		foreach (rows[r])
		begin
			packet(rows[r]);
			drain($sformatf("packet %0d", r));
		end
		chk("packet count", 16'h0004, pkt_cnt);
		byte_out(hdlrx_pkg::ABORT_PATTERN, 1'b1);
		want(hdlrx_pkg::CODE_LINK_DOWN, 9'h100);
		repeat (4) bit_out(1'b1);
		drain("abort");
		chk("link active", 16'h0000, {15'h0000, link_active});
		link_up();
		drain("flag after abort");
		arst_n   <= 1'b0;
		irq_ctrl <= 8'h08;
		cfg_word <= 32'h0000_FE03;
		poll     <= 1'b1;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		link_up();
		drain("polled link up");
		// First byte matches no address, so the whole packet is dropped
		packet(rows[2]);
		exp_c.delete();
		exp_d.delete();
		packet(rows[1]);
		drain("polled");
		chk("irq", 16'h0000, {15'h0000, i_hdlrx_if.irq});
		chk("packet count", 16'h0001, pkt_cnt);
		end_of_test();
	end
endmodule
